//--- dv/prog_mem_model.sv
// behavioural program memory answering the access block
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model (
    // address from the access block
    input  wire logic [23:0] prog_addr,
    // word returned in the same cycle
    output logic      [23:0] prog_rdata
);
    // every word differs, so a wrong address shows in the data
    assign prog_rdata = {prog_addr[8:1] ^ prog_addr[23:16],
                         prog_addr[16:1] ^ 16'hC35A};
endmodule : prog_mem_model
`default_nettype wire

//--- dv/program_space_access_properties.sv
// concurrent checks on the program space access ports
`timescale 1ns/1ps
`default_nettype none
module program_space_access_properties #(
    parameter int PHYS_WORDS = 4096
) (
    // clock, reset and requests
    input wire logic clk, rst, req_valid, pc_step, pc_load,
    input wire program_space_pkg::data_req_t     req,
    input wire program_space_pkg::ins_class_t    req_class,
    input wire program_space_pkg::repeat_state_t rpt,
    // results and registers
    input wire logic        program_window_enable, prog_rd, prog_wr_low,
    input wire logic        prog_wr_high, to_program,
    input wire logic [7:0]  table_page_reg, visibility_page_reg,
    input wire logic [22:0] pc_reg,
    input wire logic [23:0] prog_addr,
    input wire logic [15:0] rdata,
    input wire logic [1:0]  extra_cycles
);
    localparam logic [23:0] LIMIT = 24'(2 * PHYS_WORDS);
    wire logic win = req_valid && !req.table_access &&
                     program_window_enable && req.effective_addr[15];
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    a_window_gate: assert property (
        !win |=> !to_program && extra_cycles == 2'h0)
        else $error("window result without a window request");
    a_window_addr: assert property (
        win && !req.byte_op |=> prog_addr == {1'b0,
        $past(visibility_page_reg), $past(req.effective_addr[14:1]), 1'b0})
        else $error("window address wrong");
    a_table_low: assert property (
        req_valid && req.table_access |=>
        prog_addr[15:0] == $past(req.effective_addr))
        else $error("table address low half wrong");
    a_table_cfg: assert property (
        req_valid && req.table_access && table_page_reg[7] |=>
        prog_addr[23:16] == $past(table_page_reg))
        else $error("configuration page bits wrong");
    a_stall_one: assert property (
        win && !rpt.active && req_class != program_space_pkg::INS_OTHER
        |=> extra_cycles == 2'h1)
        else $error("one extra cycle expected");
    a_stall_two: assert property (
        win && (rpt.active ? |rpt[3:0]
                : req_class == program_space_pkg::INS_OTHER)
        |=> extra_cycles == 2'h2)
        else $error("two extra cycles expected");
    a_loop_single: assert property (
        win && rpt.active && !(|rpt[3:0]) |=> extra_cycles == 2'h0)
        else $error("inner loop iteration stalled");
    a_pc_step: assert property (
        pc_step && !pc_load |=> pc_reg == $past(pc_reg) + 23'h000002)
        else $error("program counter did not step by two");
    a_out_range: assert property (
        to_program && prog_addr >= LIMIT |=> rdata == 16'h0000)
        else $error("unmapped window read not zero");
    a_write_strobe: assert property (
        req_valid && req.table_write |=> !prog_rd
        && prog_wr_high == $past(req.table_high)
        && prog_wr_low != prog_wr_high)
        else $error("table write strobes wrong");
    a_fetch_addr: assert property (
        !req_valid |=> prog_addr == {1'b0, $past(pc_reg)})
        else $error("idle cycle did not present the fetch address");
endmodule : program_space_access_properties

bind program_space_access program_space_access_properties #(
    .PHYS_WORDS(PHYS_WORDS)) i_props (.clk, .rst, .req_valid, .pc_step,
    .pc_load, .req, .req_class, .rpt, .program_window_enable, .prog_rd,
    .prog_wr_low, .prog_wr_high, .to_program, .table_page_reg,
    .visibility_page_reg, .pc_reg, .prog_addr, .rdata, .extra_cycles);
`default_nettype wire

//--- dv/tb_program_space_access.sv
// self-checking bench for program space data access
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_program_space_access;
    localparam int PW = 4096;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic table_page_we, visibility_page_we, core_control_we, pc_step;
    logic program_window_enable_wdata, pc_load, req_valid;
    logic [7:0] table_page_wdata, visibility_page_wdata, tp, vp;
    logic [22:0] pc_load_value, pc_reg, pc;
    program_space_pkg::data_req_t req, q1, q2;
    program_space_pkg::ins_class_t req_class;
    program_space_pkg::repeat_state_t rpt;
    logic [23:0] prog_rdata, prog_addr, a1;
    logic prog_rd, prog_wr_low, prog_wr_high, to_program, x_space;
    logic program_window_enable, en, v1, w1, r2;
    logic [15:0] rdata, e2;
    logic [1:0] extra_cycles, s1;
    logic [7:0] table_page_reg, visibility_page_reg;
    int errors = 0;
    int check_count = 0;
    int seed = 54;
    wire logic win = req_valid && !req.table_access && en &&
                     req.effective_addr[15];

    program_space_access #(.PHYS_WORDS(PW)) i_dut (.clk, .rst, .table_page_we,
        .table_page_wdata, .visibility_page_we, .visibility_page_wdata,
        .core_control_we, .program_window_enable_wdata, .pc_step, .pc_load,
        .pc_load_value, .req_valid, .req, .req_class, .rpt, .prog_rdata,
        .prog_addr, .prog_rd, .prog_wr_low, .prog_wr_high, .rdata,
        .to_program, .x_space, .extra_cycles, .table_page_reg,
        .visibility_page_reg, .program_window_enable, .pc_reg);
    prog_mem_model i_mem (.prog_addr, .prog_rdata);

    function automatic logic [15:0] exp_rd(program_space_pkg::data_req_t r,
                                           logic [23:0] a);
        logic [23:0] p;
        logic [15:0] d;
        p = {a[8:1] ^ a[23:16], a[16:1] ^ 16'hC35A};
        if (!a[23] && a >= 24'(2 * PW)) p = 24'h000000;
        d = r.table_high ? {8'h00, p[23:16]} : p[15:0];
        if (r.byte_op) d = {8'h00, r.effective_addr[0] ? d[15:8] : d[7:0]};
        return d;
    endfunction : exp_rd

    task automatic stop_test;
        if (errors == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test

    initial forever #12.5 clk = ~clk;
    initial begin
        #100000;
        errors++;
        stop_test();
    end

    // expected state, updated on the same edges as the block
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            {tp, vp, en, pc, v1, r2} <= '0;
        end else begin
            if (table_page_we) tp <= table_page_wdata;
            if (visibility_page_we) vp <= visibility_page_wdata;
            if (core_control_we) en <= program_window_enable_wdata;
            if (pc_load) pc <= {pc_load_value[22:1], 1'b0};
            else if (pc_step) pc <= pc + 23'h000002;
            v1 <= req_valid;
            q1 <= req;
            w1 <= win;
            a1 <= req.table_access ? {tp, req.effective_addr}
                : {1'b0, vp, req.effective_addr[14:1], 1'b0};
            s1 <= !win ? 2'h0 : rpt.active ? (|rpt[3:0] ? 2'h2 : 2'h0)
                : (req_class == program_space_pkg::INS_OTHER ? 2'h2 : 2'h1);
            r2 <= v1 && (w1 || q1.table_access && !q1.table_write);
            q2 <= q1;
            e2 <= exp_rd(q1, a1);
        end
    end

    always @(negedge clk) begin
        if (!rst) begin
            `CHK(pc_reg, pc)
            `CHK({table_page_reg, visibility_page_reg}, {tp, vp})
            `CHK(program_window_enable, en)
            if (v1) begin
                `CHK(to_program, w1)
                `CHK(x_space, q1.effective_addr[15])
                `CHK(extra_cycles, s1)
                `CHK(prog_wr_high, q1.table_write & q1.table_high)
                `CHK(prog_wr_low, q1.table_write & !q1.table_high)
                `CHK(prog_rd, !q1.table_write)
                if (q1.table_access || w1 && !q1.byte_op) begin
                    `CHK(prog_addr, a1)
                end
            end
            if (r2) `CHK(rdata, e2)
        end
    end

    initial begin
        program_space_pkg::data_req_t r;
        logic quiet;
        {table_page_we, visibility_page_we, core_control_we, pc_step} = '0;
        {pc_load, program_window_enable_wdata, req_valid} = '0;
        {table_page_wdata, visibility_page_wdata, pc_load_value} = '0;
        req = '0;
        req_class = program_space_pkg::INS_OTHER;
        rpt = '0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 3000; i++) begin
            @(posedge clk);
            quiet = (i >= 1500 && i < 1502);
            rst <= quiet;
            table_page_we <= (i % 40 == 0);
            visibility_page_we <= (i % 40 == 0);
            core_control_we <= (i % 40 == 0);
            table_page_wdata <= i[6] ? 8'h00 : 8'h80 | 8'($random(seed));
            visibility_page_wdata <= i[7] ? 8'h00 : 8'($random(seed));
            program_window_enable_wdata <= (i % 200 != 0);
            r = program_space_pkg::data_req_t'($random(seed));
            if (!r.table_access) {r.table_high, r.table_write} = 2'h0;
            if (i[3]) r.effective_addr &= 16'h9FFF;
            if (i % 40 < 4) r.effective_addr = 16'h7FFF + 16'(i % 40);
            req <= r;
            req_valid <= !quiet && (i % 40 != 0) && ($random(seed) % 5 != 0);
            req_class <= program_space_pkg::ins_class_t'(3'h1 << (i % 3));
            rpt <= program_space_pkg::repeat_state_t'($random(seed));
            pc_step <= !quiet && 1'($random(seed));
            pc_load <= !quiet && (i % 16 == 5);
            pc_load_value <= 23'($random(seed));
        end
        stop_test();
    end
endmodule : tb_program_space_access
`default_nettype wire

//--- rtl/program_space_access.sv
// program space address construction, data steering and window stalls
// Function
// - every program address is 24 bits, from pc, table or window address
// - program counter is 23 bits; address space holds 4M words
// - program address steps by two per program word
// - non-table accesses stay within 0x000000..0x7FFFFE, bit 23 clear
// - table page bit 7 picks user or configuration space
// - bit 23 reaches ids and configuration; otherwise zero
// - table address bits 15:0 come from the data address
// - low table read returns bits 15:0, or the byte of bits 15:0 that data address bit 0 selects
// - high table read returns bits 23:16 zero-extended; byte 1 reads zero
// - upper byte reachable only by high-word table operations
// - upper 32 Kbytes of data map onto any 16K-word page
// - redirect only when address msb and window enable set
// - window copies data address bits 14:1; address bit 0 is zero
// - window upper bits from visibility page, bit 23 zero
// - window returns only low 16 bits of program word
// - window mapping suspended during table operations
// - upper data half always counts as x data space
// - mac prefetch or move window access adds one cycle outside loop
// - other window accesses add two cycles outside loop
// - in loop: first, last, irq exit and reentry add two cycles
// - other loop iterations complete in a single cycle
// - out-of-memory access returns all zero
`timescale 1ns/1ps
`default_nettype none
module program_space_access #(
    parameter int PHYS_WORDS = 4096
) (
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst,
    // page and control register writes
    input  wire logic                          table_page_we,
    input  wire logic [7:0]                    table_page_wdata,
    input  wire logic                          visibility_page_we,
    input  wire logic [7:0]                    visibility_page_wdata,
    input  wire logic                          core_control_we,
    input  wire logic                          program_window_enable_wdata,
    // instruction fetch
    input  wire logic                          pc_step,
    input  wire logic                          pc_load,
    input  wire logic [22:0]                   pc_load_value,
    // data access request
    input  wire logic                          req_valid,
    input  wire program_space_pkg::data_req_t  req,
    input  wire program_space_pkg::ins_class_t req_class,
    input  wire program_space_pkg::repeat_state_t rpt,
    // program memory read data
    input  wire logic [23:0]                   prog_rdata,
    // program memory address and strobes
    output logic      [23:0]                   prog_addr,
    output logic                               prog_rd,
    output logic                               prog_wr_low,
    output logic                               prog_wr_high,
    // data side results
    output logic      [15:0]                   rdata,
    output logic                               to_program,
    output logic                               x_space,
    output logic      [1:0]                    extra_cycles,
    // register read back
    output logic      [7:0]                    table_page_reg,
    output logic      [7:0]                    visibility_page_reg,
    output logic                               program_window_enable,
    output logic      [22:0]                   pc_reg
);
    logic [22:0]                pc_next;
    logic [23:0]                addr_next;
    logic [23:0]                addr_reg;
    program_space_pkg::access_kind_t kind_next;
    program_space_pkg::access_kind_t kind_reg;
    logic [15:0]                steer_data;
    logic [15:0]                rdata_next;
    logic                       window_hit;
    logic                       in_memory;
    logic                       mapped_reg;
    logic                       high_reg;
    logic                       byte_reg;
    logic                       bsel_reg;
    logic [1:0]                 extra_next;

    function automatic logic addr_present(input logic [23:0] a);
        logic [23:0] lim;
        lim = 24'(PHYS_WORDS) << 1;
        addr_present = a[program_space_pkg::CFG_BIT] || (a < lim);
    endfunction : addr_present

    // page and control registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            table_page_reg        <= program_space_pkg::TABLE_PAGE_RST;
            visibility_page_reg   <= program_space_pkg::VIS_PAGE_RST;
            program_window_enable <= 1'b0;
        end else begin
            if (table_page_we) begin
                table_page_reg <= table_page_wdata;
            end
            if (visibility_page_we) begin
                visibility_page_reg <= visibility_page_wdata;
            end
            if (core_control_we) begin
                program_window_enable <= program_window_enable_wdata;
            end
        end
    end

    always_comb begin
        pc_next = pc_reg;
        if (pc_load) begin
            pc_next = {pc_load_value[22:1], 1'b0};
        end else if (pc_step) begin
            pc_next = pc_reg + 23'h000002;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pc_reg <= 23'h000000;
        end else begin
            pc_reg <= pc_next;
        end
    end

    assign window_hit = req_valid && !req.table_access
                        && req.effective_addr[program_space_pkg::EA_MSB]
                        && program_window_enable;

    always_comb begin
        addr_next = {1'b0, pc_reg};
        kind_next = program_space_pkg::ACC_FETCH;
        if (req_valid && req.table_access) begin
            kind_next = program_space_pkg::ACC_TABLE;
            if (table_page_reg[program_space_pkg::PAGE_SEL_BIT]) begin
                addr_next = {table_page_reg, req.effective_addr};
            end else begin
                addr_next = {8'h00, req.effective_addr};
            end
        end else if (window_hit) begin
            kind_next = program_space_pkg::ACC_DATA;
            // bit 0 zero, byte from data bit 0
            addr_next = {1'b0, visibility_page_reg,
                         req.effective_addr[14:1], 1'b0};
        end
        // user accesses stay below bit 23
        if (kind_next != program_space_pkg::ACC_TABLE) begin
            addr_next[program_space_pkg::CFG_BIT] = 1'b0;
        end
    end

    // window stall cycles; one for mac prefetch and moves outside a loop
    always_comb begin
        extra_next = program_space_pkg::STALL_NONE;
        if (window_hit) begin
            if (rpt.active) begin
                if (rpt.first_iter || rpt.last_iter
                    || rpt.irq_exit || rpt.irq_reentry) begin
                    extra_next = program_space_pkg::STALL_TWO;
                end
            end else if (req_class == program_space_pkg::INS_OTHER) begin
                extra_next = program_space_pkg::STALL_TWO;
            end else begin
                extra_next = program_space_pkg::STALL_ONE;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            addr_reg   <= 24'h000000;
            kind_reg   <= program_space_pkg::ACC_NONE;
            high_reg   <= 1'b0;
            byte_reg   <= 1'b0;
            bsel_reg   <= 1'b0;
            mapped_reg <= 1'b0;
        end else begin
            addr_reg   <= addr_next;
            kind_reg   <= kind_next;
            // upper byte only on high table op
            high_reg   <= req.table_access && req.table_high;
            byte_reg   <= req.byte_op;
            bsel_reg   <= req.effective_addr[0];
            mapped_reg <= addr_present(addr_next);
        end
    end

    assign in_memory = mapped_reg
                       && (kind_reg == program_space_pkg::ACC_TABLE
                           || kind_reg == program_space_pkg::ACC_DATA);

    read_steer u_steer (
        .prog_word  (prog_rdata),
        .table_high (high_reg),
        .byte_op    (byte_reg),
        .byte_sel   (bsel_reg),
        .mapped     (in_memory),
        .data_out   (steer_data)
    );

    assign rdata_next = steer_data;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prog_addr    <= 24'h000000;
            prog_rd      <= 1'b0;
            prog_wr_low  <= 1'b0;
            prog_wr_high <= 1'b0;
            to_program   <= 1'b0;
            x_space      <= 1'b0;
            extra_cycles <= program_space_pkg::STALL_NONE;
        end else begin
            prog_addr    <= addr_next;
            prog_rd      <= !(req_valid && req.table_access
                              && req.table_write);
            prog_wr_low  <= req_valid && req.table_access
                            && req.table_write && !req.table_high;
            prog_wr_high <= req_valid && req.table_access
                            && req.table_write && req.table_high;
            to_program   <= window_hit;
            x_space      <= req_valid && req.effective_addr[15];
            extra_cycles <= extra_next;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= 16'h0000;
        end else begin
            rdata <= rdata_next;
        end
    end
endmodule : program_space_access
`default_nettype wire

//--- rtl/program_space_pkg.sv
// constants and carrier types for program space data access
package program_space_pkg;
    localparam int PADDR_W       = 24;
    localparam int PC_W          = 23;
    localparam int DATA_W        = 16;
    localparam int PAGE_W        = 8;
    localparam int WINDOW_LOW_W  = 15;
    localparam int CFG_BIT       = 23;
    localparam int PAGE_SEL_BIT  = 7;
    localparam int EA_MSB        = 15;
    localparam logic [PADDR_W-1:0] USER_MAX_ADDR = 24'h7FFFFE;
    localparam logic [PAGE_W-1:0]  TABLE_PAGE_RST = 8'h00;
    localparam logic [PAGE_W-1:0]  VIS_PAGE_RST   = 8'h00;
    localparam logic [1:0] STALL_NONE = 2'h0;
    localparam logic [1:0] STALL_ONE  = 2'h1;
    localparam logic [1:0] STALL_TWO  = 2'h2;

    typedef enum logic [3:0] {
        ACC_NONE        = 4'h1,
        ACC_FETCH       = 4'h2,
        ACC_TABLE       = 4'h4,
        ACC_DATA        = 4'h8
    } access_kind_t;

    typedef enum logic [2:0] {
        INS_MAC_PREFETCH = 3'h1,
        INS_MOVE         = 3'h2,
        INS_OTHER        = 3'h4
    } ins_class_t;

    typedef struct packed {
        logic                table_access;
        logic                table_high;
        logic                table_write;
        logic                byte_op;
        logic [DATA_W-1:0]   effective_addr;
    } data_req_t;

    typedef struct packed {
        logic                active;
        logic                first_iter;
        logic                last_iter;
        logic                irq_exit;
        logic                irq_reentry;
    } repeat_state_t;
endpackage : program_space_pkg

//--- rtl/read_steer.sv
// read data steering from a program word onto the 16-bit data path
`timescale 1ns/1ps
`default_nettype none
module read_steer (
    // program word and request shape
    input  wire logic [23:0] prog_word,
    input  wire logic        table_high,
    input  wire logic        byte_op,
    input  wire logic        byte_sel,
    input  wire logic        mapped,
    // steered result
    output logic      [15:0] data_out
);
    always_comb begin
        data_out = 16'h0000;
        if (mapped) begin
            if (!table_high) begin
                if (!byte_op) begin
                    data_out = prog_word[15:0];
                end else if (!byte_sel) begin
                    data_out = {8'h00, prog_word[7:0]};
                end else begin
                    data_out = {8'h00, prog_word[15:8]};
                end
            end else begin
                if (!byte_op || !byte_sel) begin
                    data_out = {8'h00, prog_word[23:16]};
                end
            end
        end
    end
endmodule : read_steer
`default_nettype wire
